// ---- logic/bstap_port.sv ----
// Boundary-scan test access port with its sample FIFO.
// Contract
// - Inputs sampled on test-clock rise; serial output and update stage change only on its fall.
// - Undriven mode-select reads as logic one.
// - Undriven serial data input reads as logic one.
// - Serial output drives only in shift states, changes on fall, last stage.
// - Controller resets at power-up and idles until the test clock toggles.
// - Test registers capture on rising edge, shift out on falling edge.
// - Exactly one register in the serial path, from state and instruction.
// - Instruction register is 3 bits, loadable only when in the path.
// - Instruction preset to identification at reset and Test-Logic-Reset.
// - Held instruction takes effect entering Run-Test/Idle or data states.
// - Bypass register is one stage between serial input and output.
// - Boundary register has one stage per pin plus constant-one stages.
// - Boundary register captures the ring in Capture-DR, shifts in Shift-DR.
// - External test, sample-with-float and sample/preload select boundary.
// - Identification register is 32 bits and captures a fixed constant.
// - Identification register shifts out bit 0 first.
// - Codes: extest 000, ident 001, sample-float 010, sample 100, bypass 111.
// - Codes 011, 101 and 110 act as bypass.
// - Capture-IR loads 01 into the two low instruction bits.
// - Sample-with-float forces memory outputs high impedance.
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------------------------------
// Sample FIFO
// ----------------------------------------------------------------
module bstap_fifo
    import bstap_pkg::*;
#(
    parameter int W     = 8,
    parameter int DEPTH = 4
)(
    input  wire logic         mclk,
    input  wire logic         rst_b,
    input  wire logic         clkEn,
    input  wire logic [W-1:0] inData,
    input  wire logic         inValid,
    output var  logic         inReady,
    output var  logic [W-1:0] outData,
    output var  logic         outValid,
    input  wire logic         outReady
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0]           wp;
        logic [PW-1:0]           rp;
        logic [CW-1:0]           cnt;
        logic                    notFull;
        logic                    notEmpty;
    } bstap_fifo_s;

    bstap_fifo_s f_r;
    bstap_fifo_s f_nxt;
    logic        push;
    logic        pop;

    // Pointer and count update; flags are registered with the count.
    always_comb
    begin
        f_nxt = f_r;
        push  = clkEn & inValid & f_r.notFull;
        pop   = clkEn & outReady & f_r.notEmpty;
        if (push)
        begin
            f_nxt.mem[f_r.wp] = inData;
            f_nxt.wp = (f_r.wp == PW'(DEPTH - 1)) ? '0 : f_r.wp + 1'b1;
        end
        if (pop)
        begin
            f_nxt.rp = (f_r.rp == PW'(DEPTH - 1)) ? '0 : f_r.rp + 1'b1;
        end
        f_nxt.cnt = f_r.cnt + CW'(push) - CW'(pop);
        f_nxt.notFull  = f_nxt.cnt != CW'(DEPTH);
        f_nxt.notEmpty = f_nxt.cnt != '0;
    end

    // State register.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            f_r         <= '0;
            f_r.notFull <= 1'b1;
        end
        else
        begin
            f_r <= f_nxt;
        end
    end

    assign inReady  = f_r.notFull;
    assign outValid = f_r.notEmpty;
    assign outData  = f_r.mem[f_r.rp];
endmodule

// ----------------------------------------------------------------
// Test access port top
// ----------------------------------------------------------------
module bstap_port
    import bstap_pkg::*;
#(
    parameter int          RING_W = 8,
    parameter int          PH_W   = 2,
    parameter int          FIFO_D = 4,
    parameter logic [31:0] IDCODE = 32'h1000a001  // Arbitrary value.
)(
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              clkEn,
    input  wire logic              tckPin,
    input  wire logic              tmsPin,
    input  wire logic              tmsDriven,
    input  wire logic              tdiPin,
    input  wire logic              tdiDriven,
    output var  logic              tdoOut,
    output var  logic              tdoOe_b,
    input  wire logic [RING_W-1:0] ringData,
    input  wire logic              ringValid,
    output var  logic              ringReady,
    output var  logic [RING_W-1:0] ringDrive,
    output var  logic              ringDriveEn,
    output var  logic              ramHiZ
);
    localparam int BSR_W = RING_W + PH_W;

    typedef struct packed {
        bstap_pins_s        s0;
        bstap_pins_s        s1;
        bstap_pins_s        s2;
        bstap_pins_s        filt;
        bstap_state_e       state;
        logic [IR_W-1:0]    ir;
        bstap_instr_e       irHold;
        bstap_instr_e       act;
        logic               byp;
        logic [BSR_W-1:0]   bsr;
        logic [ID_W-1:0]    id;
        logic [RING_W-1:0]  upd;
        logic               tdo;
        logic               tdoOe_b;
        logic               hiZ;
        logic               drvEn;
    } bstap_core_s;

    bstap_core_s      s_r;
    bstap_core_s      s_nxt;
    bstap_pins_s      pinNow;
    bstap_pins_s      nf;
    logic             tckRise;
    logic             tckFall;
    logic             capPop;
    logic [RING_W-1:0] fifoData;
    logic             fifoValid;

    // Register chosen by the active instruction.
    function automatic bstap_sel_e selReg(bstap_instr_e ins);
        case (ins)
            I_EXTEST, I_SAMPZ, I_SAMPLE: selReg = SEL_BSR;
            I_IDENT:                     selReg = SEL_ID;
            default:                     selReg = SEL_BYP;
        endcase
    endfunction

    // Controller transition on one rising test-clock edge.
    function automatic bstap_state_e nextState(bstap_state_e st, logic m);
        case (st)
            ST_RESET: nextState = m ? ST_RESET : ST_IDLE;
            ST_IDLE:  nextState = m ? ST_SELDR : ST_IDLE;
            ST_SELDR: nextState = m ? ST_SELIR : ST_CAPDR;
            ST_CAPDR: nextState = m ? ST_EX1DR : ST_SHDR;
            ST_SHDR:  nextState = m ? ST_EX1DR : ST_SHDR;
            ST_EX1DR: nextState = m ? ST_UPDR  : ST_PSDR;
            ST_PSDR:  nextState = m ? ST_EX2DR : ST_PSDR;
            ST_EX2DR: nextState = m ? ST_UPDR  : ST_SHDR;
            ST_UPDR:  nextState = m ? ST_SELDR : ST_IDLE;
            ST_SELIR: nextState = m ? ST_RESET : ST_CAPIR;
            ST_CAPIR: nextState = m ? ST_EX1IR : ST_SHIR;
            ST_SHIR:  nextState = m ? ST_EX1IR : ST_SHIR;
            ST_EX1IR: nextState = m ? ST_UPIR  : ST_PSIR;
            ST_PSIR:  nextState = m ? ST_EX2IR : ST_PSIR;
            ST_EX2IR: nextState = m ? ST_UPIR  : ST_SHIR;
            ST_UPIR:  nextState = m ? ST_SELDR : ST_IDLE;
            default:  nextState = ST_RESET;
        endcase
    endfunction

    // Pull-ups: an undriven mode-select or data input pin reads as one.
    always_comb
    begin
        pinNow.tck = tckPin;
        pinNow.tms = tmsDriven ? tmsPin : 1'b1;
        pinNow.tdi = tdiDriven ? tdiPin : 1'b1;
    end

    // A pin level counts once the second and third stages agree.
    always_comb
    begin
        nf.tck = (s_r.s1.tck == s_r.s2.tck) ? s_r.s2.tck : s_r.filt.tck;
        nf.tms = (s_r.s1.tms == s_r.s2.tms) ? s_r.s2.tms : s_r.filt.tms;
        nf.tdi = (s_r.s1.tdi == s_r.s2.tdi) ? s_r.s2.tdi : s_r.filt.tdi;
        tckRise = clkEn & nf.tck & ~s_r.filt.tck;
        tckFall = clkEn & ~nf.tck & s_r.filt.tck;
        capPop  = tckRise & (s_r.state == ST_CAPDR)
                & (selReg(s_r.act) == SEL_BSR);
    end

    bstap_fifo #(
        .W     (RING_W),
        .DEPTH (FIFO_D)
    ) u_fifo (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .clkEn    (clkEn),
        .inData   (ringData),
        .inValid  (ringValid),
        .inReady  (ringReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (capPop)
    );

    // Next state of the whole port.
    always_comb
    begin
        s_nxt = s_r;
        if (clkEn)
        begin
            s_nxt.s0   = pinNow;
            s_nxt.s1   = s_r.s0;
            s_nxt.s2   = s_r.s1;
            s_nxt.filt = nf;
        end
        // Rising edge: capture, shift and advance.
        if (tckRise)
        begin
            case (s_r.state)
                ST_CAPIR: s_nxt.ir = IR_CAPT;
                ST_SHIR:  s_nxt.ir = {nf.tdi, s_r.ir[IR_W-1:1]};
                ST_CAPDR:
                begin
                    case (selReg(s_r.act))
                        SEL_BSR:
                        begin
                            s_nxt.bsr[BSR_W-1:RING_W] = '1;
                            if (fifoValid)
                            begin
                                s_nxt.bsr[RING_W-1:0] = fifoData;
                            end
                        end
                        SEL_ID:  s_nxt.id = IDCODE;
                        default: s_nxt.byp = 1'b0;
                    endcase
                end
                ST_SHDR:
                begin
                    case (selReg(s_r.act))
                        SEL_BSR: s_nxt.bsr = {nf.tdi, s_r.bsr[BSR_W-1:1]};
                        SEL_ID:  s_nxt.id = {nf.tdi, s_r.id[ID_W-1:1]};
                        default: s_nxt.byp = nf.tdi;
                    endcase
                end
                default: s_nxt.byp = s_r.byp;
            endcase
            s_nxt.state = nextState(s_r.state, nf.tms);
            if (s_nxt.state == ST_RESET)
            begin
                s_nxt.ir     = I_IDENT;
                s_nxt.irHold = I_IDENT;
                s_nxt.act    = I_IDENT;
            end
            else if (s_nxt.state == ST_IDLE || s_nxt.state == ST_SELDR)
            begin
                s_nxt.act = s_r.irHold;
            end
        end
        // Falling edge: update stages and serial output.
        if (tckFall)
        begin
            if (s_r.state == ST_UPIR)
            begin
                s_nxt.irHold = bstap_instr_e'(s_r.ir);
            end
            if (s_r.state == ST_UPDR && (s_r.act == I_EXTEST
                || s_r.act == I_SAMPLE))
            begin
                s_nxt.upd = s_r.bsr[RING_W-1:0];
            end
            s_nxt.tdoOe_b = 1'b1;
            if (s_r.state == ST_SHIR)
            begin
                s_nxt.tdo     = s_r.ir[0];
                s_nxt.tdoOe_b = 1'b0;
            end
            else if (s_r.state == ST_SHDR)
            begin
                s_nxt.tdoOe_b = 1'b0;
                case (selReg(s_r.act))
                    SEL_BSR: s_nxt.tdo = s_r.bsr[0];
                    SEL_ID:  s_nxt.tdo = s_r.id[0];
                    default: s_nxt.tdo = s_r.byp;
                endcase
            end
        end
        if (clkEn)
        begin
            s_nxt.hiZ   = s_nxt.act == I_SAMPZ;
            s_nxt.drvEn = s_nxt.act == I_EXTEST;
        end
    end

    // State register; power-up reset parks the controller.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            s_r         <= '0;
            s_r.state   <= ST_RESET;
            s_r.ir      <= I_IDENT;
            s_r.irHold  <= I_IDENT;
            s_r.act     <= I_IDENT;
            s_r.tdoOe_b <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign tdoOut      = s_r.tdo;
    assign tdoOe_b     = s_r.tdoOe_b;
    assign ringDrive   = s_r.upd;
    assign ringDriveEn = s_r.drvEn;
    assign ramHiZ      = s_r.hiZ;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [2:0] onesCnt;

    // Counts consecutive rising edges seen with mode-select high.
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            onesCnt <= '0;
        end
        else if (tckRise)
        begin
            onesCnt <= nf.tms ? ((onesCnt == 3'h7) ? onesCnt
                                  : onesCnt + 3'h1) : 3'h0;
        end
    end

    a_five_ones: assert property (@(posedge mclk) disable iff (!rst_b)
        onesCnt >= 3'(RESET_RUN) |-> s_r.state == ST_RESET)
        else $error("Controller not reset after five high edges.");

    a_tdo_edge: assert property (@(posedge mclk) disable iff (!rst_b)
        !$stable(s_r.tdo) || !$stable(s_r.tdoOe_b) |-> $past(tckFall))
        else $error("Serial output changed off a falling edge.");

    a_tdo_float: assert property (@(posedge mclk) disable iff (!rst_b)
        tckFall && s_r.state != ST_SHIR && s_r.state != ST_SHDR
        |=> s_r.tdoOe_b)
        else $error("Serial output driven outside shift states.");

    a_ir_capture: assert property (@(posedge mclk) disable iff (!rst_b)
        tckRise && s_r.state == ST_CAPIR |=> s_r.ir[1:0] == IR_CAPT[1:0])
        else $error("Capture-IR did not load 01.");

    a_ir_locked: assert property (@(posedge mclk) disable iff (!rst_b)
        tckRise && s_r.state != ST_CAPIR && s_r.state != ST_SHIR
        && s_r.state != ST_SELIR |=> $stable(s_r.ir))
        else $error("Instruction changed outside its path.");

    a_tlr_preset: assert property (@(posedge mclk) disable iff (!rst_b)
        s_r.state == ST_RESET |-> s_r.act == I_IDENT
        && s_r.irHold == I_IDENT)
        else $error("Reset state without identification preset.");

    a_id_capture: assert property (@(posedge mclk) disable iff (!rst_b)
        tckRise && s_r.state == ST_CAPDR && s_r.act == I_IDENT
        |=> s_r.id == IDCODE)
        else $error("Identification constant not captured.");

    a_rfu_bypass: assert property (@(posedge mclk) disable iff (!rst_b)
        tckRise && s_r.state == ST_SHDR && (s_r.act == I_RFU3
        || s_r.act == I_RFU5 || s_r.act == I_RFU6)
        |=> s_r.byp == $past(nf.tdi) && $stable(s_r.id))
        else $error("Reserved code did not act as bypass.");

    a_hiz_float: assert property (@(posedge mclk) disable iff (!rst_b)
        tckRise && s_r.state == ST_UPIR && s_r.irHold == I_SAMPZ
        |-> ##1 s_r.act == I_SAMPZ ##1 ramHiZ)
        else $error("Sample-with-float did not float outputs.");

endmodule
`default_nettype wire

// ---- logic/bstap_pkg.sv ----
// Shared constants and types for the boundary-scan test access port.
`default_nettype none
package bstap_pkg;

    // ------------------------------------------------------------
    // Instruction register layout and codes
    // ------------------------------------------------------------
    localparam int          IR_W     = 3;
    localparam logic [2:0]  IR_CAPT  = 3'h1;  // Captured 01 in the low bits.
    localparam int          ID_W     = 32;
    localparam int          SYNC_N   = 3;
    localparam int          RESET_RUN = 5;    // Rising edges with mode high.

    typedef enum logic [2:0] {
        I_EXTEST = 3'h0,
        I_IDENT  = 3'h1,
        I_SAMPZ  = 3'h2,
        I_RFU3   = 3'h3,
        I_SAMPLE = 3'h4,
        I_RFU5   = 3'h5,
        I_RFU6   = 3'h6,
        I_BYPASS = 3'h7
    } bstap_instr_e;

    // ------------------------------------------------------------
    // Sixteen-state controller encoding
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_RESET = 4'h0, ST_IDLE  = 4'h1, ST_SELDR = 4'h2, ST_CAPDR = 4'h3,
        ST_SHDR  = 4'h4, ST_EX1DR = 4'h5, ST_PSDR  = 4'h6, ST_EX2DR = 4'h7,
        ST_UPDR  = 4'h8, ST_SELIR = 4'h9, ST_CAPIR = 4'ha, ST_SHIR  = 4'hb,
        ST_EX1IR = 4'hc, ST_PSIR  = 4'hd, ST_EX2IR = 4'he, ST_UPIR  = 4'hf
    } bstap_state_e;

    // Data register chosen for the serial path.
    typedef enum logic [1:0] {
        SEL_BYP = 2'h0,
        SEL_ID  = 2'h1,
        SEL_BSR = 2'h2
    } bstap_sel_e;

    // Test pins as seen after the pull-ups.
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bstap_pins_s;

endpackage
`default_nettype wire

// ---- bench/bstap_jtag_host.sv ----
// Behavioural test controller that clocks the port's serial link.
`timescale 1ns/1ns
`default_nettype none
module bstap_jtag_host
    import bstap_pkg::*;
#(
    parameter int HALF = 80
)(
    output var  logic tck,
    output var  logic tms,
    output var  logic tmsDriven,
    output var  logic tdi,
    output var  logic tdiDriven,
    input  wire logic tdo,
    input  wire logic tdoOe_b
);
    // The link clock rests low between frames, both lines driven high.
    initial
    begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
        tmsDriven = 1'b1;
        tdiDriven = 1'b1;
    end

    // Selects which lines are driven; a released line carries junk.
    task automatic drive(input logic m, input logic d);
        tmsDriven = m;
        tdiDriven = d;
    endtask

    // One period: lines change while low, the output is taken on the rise.
    task automatic clk1(input logic m, input logic d, output logic o,
                        output logic oe);
        tms = tmsDriven ? m : ~tms;
        tdi = tdiDriven ? d : ~tdi;
        #(HALF);
        tck = 1'b1;
        o = tdoOe_b ? ~tdo : tdo;  // A released output reads as junk.
        oe = tdoOe_b;
        #(HALF);
        tck = 1'b0;
    endtask

    // Walks the state machine with mode bits taken LSB first.
    task automatic walk(input logic [7:0] seq, input int n);
        logic o;
        logic oe;
        for (int i = 0; i < n; i++)
            clk1(seq[i], 1'b1, o, oe);
    endtask

    // Shifts n bits LSB first, leaving the shift state on the last one.
    task automatic shift(input logic [63:0] din, input int n,
                         output logic [63:0] dout, output logic oeOr);
        logic oe;
        dout = '0;
        oeOr = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            clk1(i == n - 1, din[i], dout[i], oe);
            oeOr = oeOr | oe;
        end
    endtask

    // Loads a code from Run-Test/Idle and returns to Run-Test/Idle.
    task automatic scanIr(input logic [2:0] code, output logic [2:0] cap);
        logic [63:0] o;
        logic        oe;
        walk(8'h03, 4);
        shift(64'(code), 3, o, oe);
        cap = o[2:0];
        walk(8'h01, 2);
    endtask

    // Captures, shifts and updates the selected data register.
    task automatic scanDr(input logic [63:0] din, input int n,
                          output logic [63:0] dout, output logic oeOr);
        walk(8'h01, 3);
        shift(din, n, dout, oeOr);
        walk(8'h01, 2);
    endtask
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the boundary-scan port and its sample FIFO.
`timescale 1ns/1ns
`default_nettype none
module tb
    import bstap_pkg::*;
;
    localparam logic [31:0] IDC = 32'h5a3c9617;  // Arbitrary value.
    localparam logic [63:0] PAT = 64'h0000_00c3_5a96_e1f0;

    typedef struct packed {
        logic [2:0] code;
        bstap_sel_e kind;
        logic       hiZ;
        logic       drvEn;
    } bstap_row_s;

    // Each code beside the path it selects and the pin modes it sets.
    localparam bstap_row_s ROWS [8] = '{
        '{3'h0, SEL_BSR, 1'b0, 1'b1}, '{3'h1, SEL_ID, 1'b0, 1'b0},
        '{3'h2, SEL_BSR, 1'b1, 1'b0}, '{3'h3, SEL_BYP, 1'b0, 1'b0},
        '{3'h4, SEL_BSR, 1'b0, 1'b0}, '{3'h5, SEL_BYP, 1'b0, 1'b0},
        '{3'h6, SEL_BYP, 1'b0, 1'b0}, '{3'h7, SEL_BYP, 1'b0, 1'b0}
    };

    logic        mclk;
    logic        rst_b;
    logic        clkEn;
    logic        tck;
    logic        tms;
    logic        tmsDrv;
    logic        tdi;
    logic        tdiDrv;
    logic        tdoOut;
    logic        tdoOe_b;
    logic [7:0]  ringData;
    logic        ringValid;
    logic        ringReady;
    logic [7:0]  ringDrive;
    logic        ringDriveEn;
    logic        ramHiZ;
    logic [11:0] outs;
    int          mismatches;
    int          nChecks;
    bstap_row_s  rw;
    logic [2:0]  cap;
    logic [63:0] dout;
    logic        oeOr;
    logic [39:0] exp;
    logic [7:0]  word;
    int          k;

    assign outs = {tdoOe_b, ramHiZ, ringDriveEn, ringDrive, ringReady};

    bstap_port #(
        .RING_W (8),
        .PH_W   (2),
        .FIFO_D (4),
        .IDCODE (IDC)
    ) u_bstap_port (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .clkEn       (clkEn),
        .tckPin      (tck),
        .tmsPin      (tms),
        .tmsDriven   (tmsDrv),
        .tdiPin      (tdi),
        .tdiDriven   (tdiDrv),
        .tdoOut      (tdoOut),
        .tdoOe_b     (tdoOe_b),
        .ringData    (ringData),
        .ringValid   (ringValid),
        .ringReady   (ringReady),
        .ringDrive   (ringDrive),
        .ringDriveEn (ringDriveEn),
        .ramHiZ      (ramHiZ)
    );

    bstap_jtag_host u_bstap_jtag_host (
        .tck       (tck),
        .tms       (tms),
        .tmsDriven (tmsDrv),
        .tdi       (tdi),
        .tdiDriven (tdiDrv),
        .tdo       (tdoOut),
        .tdoOe_b   (tdoOe_b)
    );

    // The system clock toggles every half period.
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // Compares one value and reports a difference.
    task automatic check(input logic [63:0] seen, input logic [63:0] want,
                         input string what);
        nChecks++;
        if (seen !== want)
        begin
            mismatches++;
            $display("ERROR %0t %s: %h, want %h", $time, what, seen, want);
        end
    endtask

    // Offers one ring word for a single cycle, then scrambles the bus.
    task automatic push(input logic [7:0] w);
        @(negedge mclk);
        ringData = w;
        ringValid = 1'b1;
        @(negedge mclk);
        ringValid = 1'b0;
        ringData = ~w;
        @(negedge mclk);
    endtask

    // Prints the verdict and ends the run.
    task automatic stop_test();
        if (mismatches == 0 && nChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Cuts a hang short.
    initial
    begin
        #400000;
        mismatches++;
        stop_test();
    end

    // Main sequence.
    initial
    begin
        mismatches = 0;
        nChecks = 0;
        rst_b = 1'b0;
        clkEn = 1'b1;
        ringData = 8'h00;
        ringValid = 1'b0;
        repeat (8) @(negedge mclk);
        rst_b = 1'b1;
        repeat (50) @(negedge mclk);
        check(64'(outs), 64'h801, "idle port");
        u_bstap_jtag_host.walk(8'h00, 1);
        // Table of codes: capture pattern, pin modes, path and update.
        for (int r = 0; r < 8; r++)
        begin
            rw = ROWS[r];
            word = 8'h90 ^ 8'(r);
            if (rw.kind == SEL_BSR)
                push(word);
            u_bstap_jtag_host.scanIr(rw.code, cap);
            check(64'(cap), 64'h1, "ir capture");
            @(negedge mclk);
            check(64'(outs[10:9]), 64'(rw[1:0]), "mode");
            u_bstap_jtag_host.scanDr(PAT, 40, dout, oeOr);
            check(64'({oeOr, tdoOe_b}), 64'h1, "tdo enable");
            case (rw.kind)
                SEL_ID:  exp = {PAT[7:0], IDC};
                SEL_BSR: exp = {PAT[29:0], 2'b11, word};
                default: exp = {PAT[38:0], 1'b0};
            endcase
            check(64'(dout[39:0]), 64'(exp), "dr");
            if (rw.code == 3'h0 || rw.code == 3'h4)
                check(64'(ringDrive), 64'(PAT[37:30]), "update");
        end
        // Fill the FIFO until it refuses, then drain it by captures.
        u_bstap_jtag_host.scanIr(3'h4, cap);
        k = 0;
        while (ringReady === 1'b1 && k < 8)
        begin
            k++;
            push(8'h11 * 8'(k));
        end
        check(64'(k), 64'h4, "fifo depth");
        push(8'hee);
        for (int i = 1; i <= 4; i++)
        begin
            u_bstap_jtag_host.scanDr(64'h0, 10, dout, oeOr);
            check(64'(dout[9:0]), 64'({2'b11, 8'h11 * 8'(i)}), "fifo");
            check(64'(ringReady), 64'h1, "fifo room");
        end
        // A released mode line inside a shift still reaches reset.
        u_bstap_jtag_host.scanIr(3'h7, cap);
        u_bstap_jtag_host.walk(8'h01, 3);
        u_bstap_jtag_host.drive(1'b0, 1'b1);
        u_bstap_jtag_host.walk(8'h00, 5);
        u_bstap_jtag_host.drive(1'b1, 1'b1);
        u_bstap_jtag_host.walk(8'h00, 1);
        u_bstap_jtag_host.scanDr(PAT, 32, dout, oeOr);
        check(64'(dout[31:0]), 64'(IDC), "reset code");
        // A released data line shifts ones through the bypass stage.
        u_bstap_jtag_host.scanIr(3'h7, cap);
        u_bstap_jtag_host.drive(1'b1, 1'b0);
        u_bstap_jtag_host.scanDr(64'h0, 8, dout, oeOr);
        check(64'(dout[7:0]), 64'hfe, "float tdi");
        // A frozen clock enable ignores five high mode edges.
        @(negedge mclk);
        clkEn = 1'b0;
        u_bstap_jtag_host.walk(8'h1f, 5);
        @(negedge mclk);
        clkEn = 1'b1;
        u_bstap_jtag_host.scanDr(64'h0, 8, dout, oeOr);
        check(64'(dout[7:0]), 64'hfe, "frozen");
        u_bstap_jtag_host.drive(1'b1, 1'b1);
        // A reset in mid-run parks the port on the identification code.
        @(negedge mclk);
        rst_b = 1'b0;
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        repeat (4) @(negedge mclk);
        check(64'(outs), 64'h801, "reset again");
        u_bstap_jtag_host.walk(8'h00, 1);
        u_bstap_jtag_host.scanDr(PAT, 32, dout, oeOr);
        check(64'(dout[31:0]), 64'(IDC), "reset ident");
        stop_test();
    end
endmodule
`default_nettype wire
